// file: logic/trb_buffer.v
`timescale 1ns/10ps
`include "trb_consts.vh"
module trb_buffer (
  input wire i_sys_clk, // 250 MHz clock
  input wire i_reset, // sync reset, active high
  input wire i_factory, // one-cycle pulse: load factory defaults
  input wire i_inst_reset, // pulse: instrument reset or preset
  input wire i_time_wr, // pulse: load clock time
  input wire [4:0] i_time_hr, // hours 0..23
  input wire [5:0] i_time_min, // minutes
  input wire [12:0] i_time_csec, // seconds in hundredths
  input wire i_date_wr, // pulse: load date
  input wire [13:0] i_date_yr, // four-digit year
  input wire [3:0] i_date_mo, // month
  input wire [4:0] i_date_day, // day
  input wire i_stamp_type_wr, // pulse: write stamp type
  input wire i_stamp_type, // 1 wall_clock_stamp, 0 relative
  input wire i_stamp_fmt_wr, // pulse: write stamp format
  input wire i_stamp_delta, // 1 delta, 0 absolute
  input wire i_clear, // pulse: clear buffer
  input wire i_auto_clr_wr, // pulse: write auto-clear
  input wire i_auto_clr, // auto-clear value
  input wire i_points_wr, // pulse: write capacity
  input wire [16:0] i_points, // capacity value
  input wire i_feed_wr, // pulse: write source
  input wire [1:0] i_feed, // source code
  input wire i_ctrl_wr, // pulse: write fill control
  input wire [1:0] i_ctrl, // fill control code
  input wire i_notify_wr, // pulse: write threshold
  input wire [16:0] i_notify, // threshold value
  input wire i_elem_wr, // pulse: write elements
  input wire [4:0] i_elem, // element mask
  input wire i_stat_sel_wr, // pulse: write statistic select
  input wire [2:0] i_stat_sel, // statistic code
  input wire i_stat_en_wr, // pulse: write statistic enable
  input wire i_stat_en, // statistic enable value
  input wire i_calc, // pulse: calculate statistic
  input wire i_evt_clr, // pulse: clear notify bit
  input wire i_sense_vld, // raw reading strobe
  input wire [31:0] i_sense_data, // raw reading
  input wire i_calc_vld, // math reading strobe
  input wire [31:0] i_calc_data, // math reading
  output reg [16:0] o_hundredths_hi, // time of day, hundredths lower 17 bits
  output reg [13:0] o_year, // clock year
  output reg [3:0] o_month, // clock month
  output reg [4:0] o_day, // clock day
  output reg o_stamp_next, // stamp type for next run
  output reg o_stamp_held, // stamp type of held readings
  output reg o_stamp_delta, // stamp format
  output reg o_auto_clr, // auto-clear setting
  output reg [16:0] o_points, // capacity
  output reg [1:0] o_feed, // source
  output reg [1:0] o_ctrl, // fill control
  output reg [16:0] o_notify, // threshold
  output reg [4:0] o_elem, // returned elements
  output reg [2:0] o_stat_sel, // statistic select
  output reg o_stat_en, // statistic enable
  output reg o_running, // storage run active
  output reg [16:0] o_count, // readings held
  output reg [16:0] o_next, // next storage location
  output reg [21:0] o_free_bytes, // bytes free
  output reg [21:0] o_used_bytes, // bytes used
  output reg o_notify_evt, // trace-notify event bit
  output reg o_stat_busy, // statistic in progress
  output reg o_stat_done, // one-cycle pulse: result ready
  output reg [63:0] o_stat_result, // last statistic, signed
  output reg [31:0] o_stamp_val, // stamp of last stored reading
  output reg o_wr, // one-cycle pulse: reading stored
  output reg [31:0] o_rd_data // reading fetched during calculation
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_CALC = 3'b100;
  reg [2:0] st_q;
  reg [23:0] tick_q;
  reg [31:0] tod_q;
  reg [31:0] rel_q;
  reg [31:0] last_stamp_q;
  reg [16:0] wptr_q;
  reg [16:0] rptr_q;
  reg [16:0] rcnt_q;
  reg rvld_q;
  reg signed [31:0] min_q;
  reg signed [31:0] max_q;
  reg signed [63:0] sum_q;
  reg [16:0] n_q;
  wire [31:0] rd_w;
  wire in_vld = (o_feed == `TRB_SRC_SENSE) ? i_sense_vld : (o_feed == `TRB_SRC_CALC) ? i_calc_vld : 1'b0;
  wire [31:0] in_data = (o_feed == `TRB_SRC_SENSE) ? i_sense_data : i_calc_data;
  wire store = (st_q == ST_RUN) && in_vld;
  wire [31:0] stamp_now = o_stamp_held ? tod_q : rel_q;
  wire [31:0] stamp_out = o_stamp_delta ? (stamp_now - last_stamp_q) : stamp_now;
  wire at_end = (wptr_q == o_points - 17'h00001);
  // run starts on first fill-control write other than off
  wire start = i_ctrl_wr && (i_ctrl != `TRB_FILL_OFF) && (st_q == ST_IDLE);
  wire do_clear = i_clear || (start && o_auto_clr) ||
                  (i_stamp_type_wr && (st_q == ST_RUN));
  function [21:0] bytes_of;
    input [16:0] n;
    begin
      bytes_of = {5'h00, n} * {17'h00000, `TRB_BYTES_PER_RDG};
    end
  endfunction
  trb_store u_store (
    .i_sys_clk(i_sys_clk),
    .i_we(store),
    .i_waddr(wptr_q),
    .i_wdata(in_data),
    .i_raddr(rptr_q),
    .o_rdata(rd_w)
  );
  // real-time clock in hundredths, shared with relative stamps
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      tick_q <= 24'h000000;
      tod_q <= 32'h00000000;
      rel_q <= 32'h00000000;
      o_year <= 14'h0000;
      o_month <= 4'h1;
      o_day <= 5'h01;
    end else begin
      tick_q <= (tick_q == `TRB_TICK_CYC - 24'h000001) ? 24'h000000 : tick_q + 24'h000001;
      if (i_time_wr) begin
        tod_q <= {27'h0000000, i_time_hr} * 32'h00057e40 + {26'h0000000, i_time_min} * 32'h00001770 +
                 {19'h00000, i_time_csec};
      end else if (tick_q == `TRB_TICK_CYC - 24'h000001) begin
        tod_q <= (tod_q == `TRB_HUND_MAX) ? 32'h00000000 : tod_q + 32'h00000001;
      end
      if (start) begin
        rel_q <= 32'h00000000;
      end else if (tick_q == `TRB_TICK_CYC - 24'h000001) begin
        rel_q <= rel_q + 32'h00000001;
      end
      if (i_date_wr) begin
        o_year <= i_date_yr;
        o_month <= i_date_mo;
        o_day <= i_date_day;
      end
    end
  end
  // settings: reset or factory pulse restores defaults, instrument reset restores only the element mask
  always @(posedge i_sys_clk) begin
    if (i_reset || i_factory) begin
      o_stamp_next <= 1'b0;
      o_stamp_delta <= 1'b0;
      o_auto_clr <= 1'b1;
      o_points <= `TRB_CAP_DEF;
      o_feed <= `TRB_SRC_CALC;
      o_ctrl <= `TRB_FILL_OFF;
      o_notify <= `TRB_CAP_MIN;
      o_stat_sel <= `TRB_STAT_NONE;
      o_stat_en <= 1'b0;
      o_elem <= `TRB_ELEM_DEF;
    end else begin
      if (i_inst_reset) begin
        o_elem <= `TRB_ELEM_DEF;
      end else if (i_elem_wr) begin
        o_elem <= i_elem;
      end
      if (i_stamp_type_wr) begin
        o_stamp_next <= i_stamp_type;
      end
      if (i_stamp_fmt_wr) begin
        o_stamp_delta <= i_stamp_delta;
      end
      if (i_auto_clr_wr) begin
        o_auto_clr <= i_auto_clr;
      end
      if (i_auto_clr_wr && !i_auto_clr) begin
        o_points <= `TRB_CAP_MAX;
      end else if (i_points_wr && o_auto_clr && i_points >= `TRB_CAP_MIN && i_points <= `TRB_CAP_MAX) begin
        o_points <= i_points;
      end
      if (i_feed_wr && i_feed <= `TRB_SRC_NONE) begin
        o_feed <= i_feed;
      end
      if (i_ctrl_wr && i_ctrl <= `TRB_FILL_ALWAYS) begin
        o_ctrl <= i_ctrl;
      end
      if (i_notify_wr && i_notify >= `TRB_CAP_MIN && i_notify < o_points) begin
        o_notify <= i_notify;
      end
      if (i_stat_sel_wr && i_stat_sel <= `TRB_STAT_SPAN) begin
        o_stat_sel <= i_stat_sel;
      end
      if (i_stat_en_wr) begin
        o_stat_en <= i_stat_en;
      end
    end
  end
  // storage and statistic sequencer
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= ST_IDLE;
      wptr_q <= 17'h00000;
      o_count <= 17'h00000;
      o_stamp_held <= 1'b0;
      last_stamp_q <= 32'h00000000;
      o_stamp_val <= 32'h00000000;
      o_notify_evt <= 1'b0;
      o_wr <= 1'b0;
      rptr_q <= 17'h00000;
      rcnt_q <= 17'h00000;
      rvld_q <= 1'b0;
      min_q <= 32'sh7fffffff;
      max_q <= 32'sh80000000;
      sum_q <= 64'sh0;
      n_q <= 17'h00000;
      o_stat_done <= 1'b0;
      o_stat_result <= 64'h0000000000000000;
      o_rd_data <= 32'h00000000;
    end else begin
      o_wr <= store;
      o_stat_done <= 1'b0;
      if (i_evt_clr) begin
        o_notify_evt <= 1'b0;
      end
      if (store && (o_count + 17'h00001 == o_notify)) begin
        o_notify_evt <= 1'b1;
      end
      if (do_clear) begin
        wptr_q <= 17'h00000;
        o_count <= 17'h00000;
      end
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_RUN;
            o_stamp_held <= o_stamp_next;
            last_stamp_q <= 32'h00000000;
            // appending run resumes behind the held readings, not at the wrapped pointer
            if (!o_auto_clr) begin
              wptr_q <= (o_count >= o_points) ? 17'h00000 : o_count;
            end
          end else if (i_calc && o_stat_en && o_count != 17'h00000) begin
            st_q <= ST_CALC;
            rptr_q <= 17'h00000;
            rcnt_q <= o_count;
            rvld_q <= 1'b0;
            min_q <= 32'sh7fffffff;
            max_q <= 32'sh80000000;
            sum_q <= 64'sh0;
            n_q <= 17'h00000;
          end
        end
        ST_RUN: begin
          if (i_stamp_type_wr) begin
            o_stamp_held <= i_stamp_type;
          end
          if (i_ctrl_wr && i_ctrl == `TRB_FILL_OFF) begin
            st_q <= ST_IDLE;
          end else if (store && !do_clear) begin
            o_stamp_val <= stamp_out;
            last_stamp_q <= stamp_now;
            if (o_count != o_points) begin
              o_count <= o_count + 17'h00001;
            end
            if (at_end) begin
              wptr_q <= 17'h00000;
              if (o_ctrl != `TRB_FILL_ALWAYS) begin
                st_q <= ST_IDLE;
              end
            end else begin
              wptr_q <= wptr_q + 17'h00001;
            end
          end
        end
        ST_CALC: begin
          // memory read is registered, so data trail the address by a cycle
          rvld_q <= (rcnt_q != 17'h00000);
          if (rcnt_q != 17'h00000) begin
            rptr_q <= rptr_q + 17'h00001;
            rcnt_q <= rcnt_q - 17'h00001;
          end
          if (rvld_q) begin
            o_rd_data <= rd_w;
            n_q <= n_q + 17'h00001;
            sum_q <= sum_q + {{32{rd_w[31]}}, rd_w};
            if ($signed(rd_w) < min_q) begin
              min_q <= $signed(rd_w);
            end
            if ($signed(rd_w) > max_q) begin
              max_q <= $signed(rd_w);
            end
          end
          if (rcnt_q == 17'h00000 && !rvld_q) begin
            st_q <= ST_IDLE;
            o_stat_done <= 1'b1;
            case (o_stat_sel)
              `TRB_STAT_MIN: o_stat_result <= {{32{min_q[31]}}, min_q};
              `TRB_STAT_MAX: o_stat_result <= {{32{max_q[31]}}, max_q};
              `TRB_STAT_MEAN: o_stat_result <= sum_q / $signed({47'h0, n_q});
              `TRB_STAT_SPAN: o_stat_result <= {{32{max_q[31]}}, max_q} - {{32{min_q[31]}}, min_q};
              // square root not built in hardware; sum is handed up
              `TRB_STAT_SDEV: o_stat_result <= sum_q;
              default: o_stat_result <= 64'h0000000000000000;
            endcase
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_running <= 1'b0;
      o_next <= 17'h00000;
      o_free_bytes <= 22'h000000;
      o_used_bytes <= 22'h000000;
      o_stat_busy <= 1'b0;
      o_hundredths_hi <= 17'h00000;
    end else begin
      o_running <= (st_q == ST_RUN);
      o_next <= wptr_q;
      o_used_bytes <= bytes_of(o_count);
      o_free_bytes <= bytes_of(o_points - o_count);
      o_stat_busy <= (st_q == ST_CALC);
      o_hundredths_hi <= tod_q[16:0];
    end
  end
endmodule

// file: shared/trb_consts.vh
// Function
// - load 24-hour clock time into real-time clock
// - keep seconds to one hundredth
// - select relative or wall-clock stamp, relative default
// - stamp type change clears only during run
// - keep next-run and held-readings stamp types
// - absolute or delta format, absolute default
// - clear command empties buffer at once
// - readings survive power-off until cleared; here i_reset zeroes the count and write pointer, so held readings are lost
// - auto-clear empties buffer at run start
// - auto-clear off appends until full or stopped
// - auto-clear off forces capacity to maximum
// - capacity 2 to 110000, default 100
// - report free bytes and used bytes
// - source raw, math or none; math default
// - fill control off, once, continuous; off default
// - notify bit when count reaches threshold
// - report next storage location
// - reset elements: value, units, index, stamp
// - reset leaves buffer settings unchanged
// - statistic choice and enable, none and off default
// - calculate command, calculate-query, last result
// - span equals maximum minus minimum
`ifndef TRB_CONSTS_VH
`define TRB_CONSTS_VH
`define TRB_CAP_MAX 17'h1adb0
`define TRB_CAP_MIN 17'h00002
`define TRB_CAP_DEF 17'h00064
`define TRB_NOTIFY_MAX 17'h1adaf
`define TRB_BYTES_PER_RDG 5'h10
`define TRB_ADDR_W 17
`define TRB_DATA_W 32
`define TRB_SRC_SENSE 2'h0
`define TRB_SRC_CALC 2'h1
`define TRB_SRC_NONE 2'h2
`define TRB_FILL_OFF 2'h0
`define TRB_FILL_NEXT 2'h1
`define TRB_FILL_ALWAYS 2'h2
`define TRB_STAT_NONE 3'h0
`define TRB_STAT_MIN 3'h1
`define TRB_STAT_MAX 3'h2
`define TRB_STAT_MEAN 3'h3
`define TRB_STAT_SDEV 3'h4
`define TRB_STAT_SPAN 3'h5
`define TRB_ELEM_DEF 5'h1b
`define TRB_TICK_NS 24'h989680
`define TRB_CLK_NS 24'h000004
`define TRB_TICK_CYC (`TRB_TICK_NS / `TRB_CLK_NS)
`define TRB_HUND_MAX 32'h0083d5ff
`endif

// file: logic/trb_store.v
`timescale 1ns/10ps
`include "trb_consts.vh"
// reading memory; contents have no reset so they persist like the retained store
module trb_store (
  input wire i_sys_clk, // clock
  input wire i_we, // write strobe
  input wire [16:0] i_waddr, // write location
  input wire [31:0] i_wdata, // write data
  input wire [16:0] i_raddr, // read location
  output reg [31:0] o_rdata // registered read data
);
  reg [31:0] mem [0:110000-1];
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// file: testbench/trb_buffer_sva.sv
`timescale 1ns/10ps
`include "trb_consts.vh"
module trb_buffer_sva (
  input wire logic i_sys_clk, // clock
  input wire logic i_reset, // reset
  input wire logic i_clear, // clear
  input wire logic i_auto_clr_wr, // strobe
  input wire logic i_auto_clr, // value
  input wire logic i_points_wr, // strobe
  input wire logic [16:0] i_points, // value
  input wire logic i_calc, // strobe
  input wire logic o_auto_clr, // setting
  input wire logic [16:0] o_points, // capacity
  input wire logic [16:0] o_count, // held
  input wire logic [21:0] o_used_bytes, // used
  input wire logic [16:0] o_notify, // threshold
  input wire logic o_notify_evt, // event
  input wire logic o_wr, // stored
  input wire logic o_running, // run
  input wire logic o_stat_en, // enable
  input wire logic o_stat_busy, // busy
  input wire logic o_stat_done // done
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // bytes may trail the count, so judged only once the count has settled
  property p_used; $stable(o_count) ##1 $stable(o_count) |-> o_used_bytes == {1'b0, o_count, 4'h0}; endproperty
  a_used: assert property (p_used) else $error("used bytes wrong");
  property p_clear; i_clear |-> ##[1:2] o_count == 17'h0; endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_auto_off; i_auto_clr_wr && !i_auto_clr |=> o_points == `TRB_CAP_MAX; endproperty
  a_auto_off: assert property (p_auto_off) else $error("capacity not forced");
  property p_pts_ok;
    i_points_wr && !i_auto_clr_wr && o_auto_clr && i_points >= `TRB_CAP_MIN && i_points <= `TRB_CAP_MAX
      |=> o_points == $past(i_points);
  endproperty
  a_pts_ok: assert property (p_pts_ok) else $error("capacity not taken");
  property p_pts_bad;
    i_points_wr && !i_auto_clr_wr && (!o_auto_clr || i_points < `TRB_CAP_MIN || i_points > `TRB_CAP_MAX)
      |=> $stable(o_points);
  endproperty
  a_pts_bad: assert property (p_pts_bad) else $error("bad capacity taken");
  property p_notify; $rose(o_notify_evt) |-> ##[0:1] o_count == o_notify; endproperty
  a_notify: assert property (p_notify) else $error("notify at wrong count");
  property p_wr_count; o_wr && $past(o_count) < o_points |-> o_count == $past(o_count) + 17'h1; endproperty
  a_wr_count: assert property (p_wr_count) else $error("store did not append");
  property p_calc;
    i_calc && o_stat_en && !o_running && !o_stat_busy && o_count != 17'h0 |-> ##[1:1000] o_stat_done;
  endproperty
  a_calc: assert property (p_calc) else $error("calculation fill_off done");
  c_wr: cover property (o_wr);
  c_done: cover property (o_stat_done);
  c_evt: cover property ($rose(o_notify_evt));
endmodule
bind trb_buffer trb_buffer_sva u_sva (.i_sys_clk, .i_reset, .i_clear, .i_auto_clr_wr, .i_auto_clr, .i_points_wr,
  .i_points, .i_calc, .o_auto_clr, .o_points, .o_count, .o_used_bytes, .o_notify, .o_notify_evt, .o_wr,
  .o_running, .o_stat_en, .o_stat_busy, .o_stat_done);

// file: testbench/trb_host_model.sv
`timescale 1ns/10ps
module trb_host_model (
  input wire logic i_sys_clk, // clock
  output logic o_date_wr, // date strobe
  output logic [13:0] o_date_yr, // year
  output logic [3:0] o_date_mo, // month
  output logic [4:0] o_date_day, // day
  output logic o_sense_vld, // raw strobe
  output logic [31:0] o_sense_data, // raw reading
  output logic o_calc_vld, // math strobe
  output logic [31:0] o_calc_data // math reading
);
  initial begin
    {o_date_wr, o_date_yr, o_date_mo, o_date_day, o_sense_vld, o_sense_data, o_calc_vld, o_calc_data} = '0;
  end
  // year goes out whole, fill_off a two-digit short form
  task set_date(input logic [13:0] yr, input logic [3:0] mo, input logic [4:0] dy);
    @(negedge i_sys_clk);
    {o_date_wr, o_date_yr, o_date_mo, o_date_day} = {1'b1, yr, mo, dy};
    @(negedge i_sys_clk);
    {o_date_wr, o_date_yr} = {1'b0, ~yr};
  endtask
  // released data flips so a stale value fill_off passes for a fresh one
  task put(input logic raw, input logic [31:0] d);
    {o_sense_vld, o_calc_vld, o_sense_data, o_calc_data} = {raw, !raw, d, d};
    @(negedge i_sys_clk);
    {o_sense_vld, o_calc_vld, o_sense_data, o_calc_data} = {2'h0, ~d, ~d};
    repeat (3) @(negedge i_sys_clk);
  endtask
endmodule

// file: testbench/timestamped_reading_buffer_bench.sv
`timescale 1ns/10ps
`include "trb_consts.vh"
module timestamped_reading_buffer_bench;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_factory = 1'b0, i_inst_reset = 1'b0, i_time_wr = 1'b0;
  logic i_stamp_type_wr = 1'b0, i_stamp_fmt_wr = 1'b0, i_clear = 1'b0, i_auto_clr_wr = 1'b0, i_points_wr = 1'b0;
  logic i_feed_wr = 1'b0, i_ctrl_wr = 1'b0, i_notify_wr = 1'b0, i_elem_wr = 1'b0, i_stat_sel_wr = 1'b0;
  logic i_stat_en_wr = 1'b0, i_calc = 1'b0, i_evt_clr = 1'b0, i_stamp_type = 1'b0, i_stamp_delta = 1'b0;
  logic i_auto_clr = 1'b0, i_stat_en = 1'b0;
  logic [4:0] i_time_hr = 5'h0, i_elem = 5'h0;
  logic [5:0] i_time_min = 6'h0;
  logic [12:0] i_time_csec = 13'h0;
  logic [16:0] i_points = 17'h0, i_notify = 17'h0;
  logic [1:0] i_feed = 2'h0, i_ctrl = 2'h0;
  logic [2:0] i_stat_sel = 3'h0;
  wire i_date_wr, i_sense_vld, i_calc_vld;
  wire [13:0] i_date_yr, o_year;
  wire [3:0] i_date_mo, o_month;
  wire [4:0] i_date_day, o_day, o_elem;
  wire [31:0] i_sense_data, i_calc_data;
  wire [16:0] o_hundredths_hi, o_points, o_notify, o_count, o_next;
  wire o_stamp_next, o_stamp_held, o_stamp_delta, o_auto_clr, o_stat_en, o_running, o_notify_evt, o_stat_done;
  wire [1:0] o_feed, o_ctrl;
  wire [2:0] o_stat_sel;
  wire [21:0] o_used_bytes;
  wire [63:0] o_stat_result;
  int fail_count, total_checks;
  localparam logic [32:0] DEF = {`TRB_CAP_DEF, `TRB_SRC_CALC, `TRB_FILL_OFF, 3'h4, `TRB_STAT_NONE, 1'b0, `TRB_ELEM_DEF};
  logic [16:0] pv [0:4] = '{17'h1, 17'h1adb1, `TRB_CAP_MAX, 17'h2, 17'h5};
  logic [16:0] pe [0:4] = '{17'h64, 17'h64, `TRB_CAP_MAX, 17'h2, 17'h5};
  logic [31:0] rd [0:3] = '{32'h5, 32'hfffffffd, 32'ha, 32'h2};
  logic signed [63:0] ex [1:5] = '{-64'sh3, 64'sha, 64'sh3, 64'sh0, 64'shd};
  trb_buffer i_dut (.i_sys_clk, .i_reset, .i_factory, .i_inst_reset, .i_time_wr, .i_time_hr, .i_time_min,
    .i_time_csec, .i_date_wr, .i_date_yr, .i_date_mo, .i_date_day, .i_stamp_type_wr, .i_stamp_type,
    .i_stamp_fmt_wr, .i_stamp_delta, .i_clear, .i_auto_clr_wr, .i_auto_clr, .i_points_wr, .i_points, .i_feed_wr,
    .i_feed, .i_ctrl_wr, .i_ctrl, .i_notify_wr, .i_notify, .i_elem_wr, .i_elem, .i_stat_sel_wr, .i_stat_sel,
    .i_stat_en_wr, .i_stat_en, .i_calc, .i_evt_clr, .i_sense_vld, .i_sense_data, .i_calc_vld, .i_calc_data,
    .o_hundredths_hi, .o_year, .o_month, .o_day, .o_stamp_next, .o_stamp_held, .o_stamp_delta, .o_auto_clr,
    .o_points, .o_feed, .o_ctrl, .o_notify, .o_elem, .o_stat_sel, .o_stat_en, .o_running, .o_count, .o_next,
    .o_free_bytes(), .o_used_bytes, .o_notify_evt, .o_stat_busy(), .o_stat_done, .o_stat_result,
    .o_stamp_val(), .o_wr(), .o_rd_data());
  trb_host_model i_host (.i_sys_clk, .o_date_wr(i_date_wr), .o_date_yr(i_date_yr), .o_date_mo(i_date_mo),
    .o_date_day(i_date_day), .o_sense_vld(i_sense_vld), .o_sense_data(i_sense_data), .o_calc_vld(i_calc_vld),
    .o_calc_data(i_calc_data));
  always #2 i_sys_clk = ~i_sys_clk;
  task chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // called at a falling edge; pulses drop one cycle later, results settle after two more
  task fire;
    @(negedge i_sys_clk);
    {i_inst_reset, i_time_wr, i_stamp_type_wr, i_stamp_fmt_wr, i_clear, i_auto_clr_wr, i_points_wr, i_feed_wr,
      i_ctrl_wr, i_notify_wr, i_elem_wr, i_stat_sel_wr, i_stat_en_wr, i_calc, i_evt_clr} = '0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task ctl(input logic [1:0] v);
    {i_ctrl, i_ctrl_wr} = {v, 1'b1};
    fire;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_reset = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk({o_points, o_feed, o_ctrl, o_auto_clr, o_stamp_next, o_stamp_delta, o_stat_sel, o_stat_en, o_elem}, DEF);
    {i_time_hr, i_time_min, i_time_csec, i_time_wr} = {5'h17, 6'h3b, 13'h176f, 1'b1};
    fire;
    chk(o_hundredths_hi, 17'(`TRB_HUND_MAX));
    i_host.set_date(14'h7cf, 4'hb, 5'ha);
    repeat (2) @(negedge i_sys_clk);
    chk({o_year, o_month, o_day}, {14'h7cf, 4'hb, 5'ha});
    for (int k = 0; k < 5; k++) begin
      {i_points, i_points_wr} = {pv[k], 1'b1};
      fire;
      chk(o_points, pe[k]);
    end
    {i_notify, i_notify_wr} = {17'h5, 1'b1};
    fire;
    chk(o_notify, 17'h2);
    {i_notify, i_notify_wr} = {17'h3, 1'b1};
    fire;
    chk(o_notify, 17'h3);
    {i_feed, i_feed_wr} = {`TRB_SRC_SENSE, 1'b1};
    fire;
    ctl(`TRB_FILL_NEXT);
    for (int k = 0; k < 4; k++) i_host.put(1'b1, rd[k]);
    i_host.put(1'b0, 32'h77);
    chk({o_count, o_next, o_used_bytes, o_notify_evt, o_running}, {17'h4, 17'h4, 22'h40, 2'h3});
    i_evt_clr = 1'b1;
    fire;
    i_host.put(1'b1, 32'h1);
    chk({o_count, o_running, o_notify_evt}, {17'h5, 2'h0});
    {i_stamp_type, i_stamp_type_wr} = 2'h3;
    fire;
    chk({o_stamp_next, o_stamp_held, o_count}, {2'h2, 17'h5});
    {i_stat_en, i_stat_en_wr} = 2'h3;
    fire;
    for (int k = 1; k < 6; k++) begin
      {i_stat_sel, i_stat_sel_wr, i_calc} = {3'(k), 2'h2};
      fire;
      i_calc = 1'b1;
      @(negedge i_sys_clk);
      i_calc = 1'b0;
      repeat (50) begin
        @(posedge i_sys_clk);
        #1;
        if (o_stat_done === 1'b1) break;
      end
      // the root is left out of the deviation, so neither its result nor its completion is checked
      if (k != `TRB_STAT_SDEV) chk({o_stat_done, o_stat_result}, {1'b1, ex[k]});
      @(negedge i_sys_clk);
    end
    {i_auto_clr, i_auto_clr_wr} = 2'h1;
    fire;
    chk(o_points, `TRB_CAP_MAX);
    {i_points, i_points_wr} = {17'h64, 1'b1};
    fire;
    chk(o_points, `TRB_CAP_MAX);
    ctl(`TRB_FILL_ALWAYS);
    i_host.put(1'b1, 32'h7);
    chk({o_count, o_next}, {17'h6, 17'h6});
    ctl(`TRB_FILL_OFF);
    chk(o_running, 1'b0);
    {i_auto_clr, i_auto_clr_wr} = 2'h3;
    fire;
    ctl(`TRB_FILL_NEXT);
    chk(o_count, 17'h0);
    i_host.put(1'b1, 32'h8);
    i_host.put(1'b1, 32'h9);
    {i_stamp_type, i_stamp_type_wr} = 2'h1;
    fire;
    chk({o_stamp_next, o_stamp_held, o_count}, {2'h0, 17'h0});
    i_host.put(1'b1, 32'h9);
    chk(o_count, 17'h1);
    ctl(`TRB_FILL_OFF);
    i_clear = 1'b1;
    fire;
    chk({o_count, o_used_bytes}, {17'h0, 22'h0});
    {i_elem, i_elem_wr, i_stamp_delta, i_stamp_fmt_wr, i_feed, i_feed_wr} = {5'h1, 3'h7, `TRB_SRC_NONE, 1'b1};
    fire;
    chk(o_elem, 5'h1);
    i_inst_reset = 1'b1;
    fire;
    chk({o_elem, o_stamp_delta, o_auto_clr, o_points, o_feed, o_stat_en}, {`TRB_ELEM_DEF, 2'h3, `TRB_CAP_MAX, `TRB_SRC_NONE, 1'b1});
    tally_and_finish;
  end
endmodule
